// file: hdl/ds3_mframe_overhead_map.sv
// Chosen here: the plain strobed port.
`timescale 1ns/1ps

// Functional notes
// R1 - Multiframe is 4760 bits: 56 overhead, 4704 payload.
// R2 - Payload runs in 84-bit groups, one overhead bit between groups.
// R3 - Seven subframes of 680 bits; subframe index counts 1 to 7.
// R4 - Subframe is eight 85-bit blocks; first bit overhead, rest payload.
// R5 - Mode register 0x00 bit 2 picks format: 0 C-bit Parity, 1 M13.
// R6 - One format setting serves transmit and receive together.
// R7 - Subframes 5,6,7 lead bits carry alignment 0,1,0.
// R8 - Each subframe carries alignment bits 1,0,0,1; 28 per multiframe.
// R9 - M13 receive: stuff used when two of three C-bits are 1.
// R10 - C-bit Parity: C-bits of 3,4,5 are path parity, error, link.
// R11 - C-bit Parity: subframe 1 id/network/alarm; 2,6,7 user link.
// R12 - Block parity in both formats; path parity only in C-bit Parity.
// R13 - Slot order: lead, F1, C, F0, C, F0, C, F1.
// R14 - Even parity over payload goes into next multiframe's P-bits.
// R15 - Both P-bits in a multiframe carry the same value.

module ds3_mframe_overhead_map
  import ds3_map_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       tx_pay_data,
  input  wire logic       tx_pay_valid,
  output logic            tx_pay_ready,
  input  wire logic       tx_c_data,
  input  wire logic       tx_x_data,
  output logic            tx_line_data,
  output logic            tx_line_valid,
  output logic            tx_mframe_start,
  output logic            tx_pay_slot,
  input  wire logic       rx_line_data,
  input  wire logic       rx_line_valid,
  input  wire logic       rx_mframe_start,
  output logic            rx_pay_data,
  output logic            rx_pay_valid,
  output logic            rx_cbit_valid,
  output logic            rx_stuff_used,
  output logic            rx_cbit_parity_fmt
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] rdata;
    logic [6:0] tx_bit;
    logic [2:0] tx_blk;
    logic [2:0] tx_sf;
    logic       tx_par;
    logic       tx_pbit;
    logic       tx_data;
    logic       tx_valid;
    logic       tx_start;
    logic       tx_slot;
    logic [6:0] rx_bit;
    logic [2:0] rx_blk;
    logic [2:0] rx_sf;
    logic [1:0] rx_ones;
    logic [6:0] rx_stuff;
    logic       rx_data;
    logic       rx_valid;
    logic       rx_cvalid;
    logic       rx_used;
  } state_t;

  state_t state_reg;
  state_t state_next;

  oh_kind_t   tx_kind;
  oh_kind_t   rx_kind;
  logic [1:0] tx_cidx;
  logic [1:0] rx_cidx;
  logic       fifo_data;
  logic       fifo_valid;
  logic       fifo_pop;
  logic       format_m13;

  // ----------------------------------------------------------------
  // Slot decoders and payload buffer
  // ----------------------------------------------------------------
  ds3_oh_slot u_tx_slot (
    .bit_in_block (state_reg.tx_bit),
    .block_idx    (state_reg.tx_blk),
    .kind         (tx_kind),
    .cbit_idx     (tx_cidx)
  );

  ds3_oh_slot u_rx_slot (
    .bit_in_block (state_reg.rx_bit),
    .block_idx    (state_reg.rx_blk),
    .kind         (rx_kind),
    .cbit_idx     (rx_cidx)
  );

  ds3_bit_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_data   (tx_pay_data),
    .in_valid  (tx_pay_valid),
    .in_ready  (tx_pay_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  assign format_m13 = state_reg.mode[FORMAT_BIT];  // R5 R6

  // Line stalls on an empty buffer rather than inventing payload
  assign fifo_pop = (tx_kind == OH_PAYLOAD) && fifo_valid;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic tx_adv;
    logic tx_bit_val;
    logic rx_maj;
    tx_adv     = 1'b0;
    tx_bit_val = 1'b0;
    rx_maj     = 1'b0;
    state_next = state_reg;

    // Register port
    if (reg_wr && reg_addr == MODE_CTRL_OFFSET) begin
      state_next.mode = reg_wdata;  // R5
    end
    state_next.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        MODE_CTRL_OFFSET:    state_next.rdata = state_reg.mode;
        OH_STATUS_OFFSET:    state_next.rdata = {1'b0, state_reg.rx_sf,
                                                 1'b0, state_reg.tx_sf};
        STUFF_STATUS_OFFSET: state_next.rdata = {1'b0, state_reg.rx_stuff};
        default:             state_next.rdata = 8'h00;
      endcase
    end

    // Transmit overhead insertion
    case (tx_kind)
      OH_LEAD: begin
        tx_adv = 1'b1;
        if (state_reg.tx_sf <= 3'h2) begin
          tx_bit_val = tx_x_data;
        end else if (state_reg.tx_sf <= 3'h4) begin
          tx_bit_val = state_reg.tx_pbit;  // R14 R15 R12
        end else begin
          tx_bit_val = (state_reg.tx_sf == 3'h6);  // R7
        end
      end
      OH_ALIGN1: begin
        tx_adv     = 1'b1;
        tx_bit_val = 1'b1;  // R8
      end
      OH_ALIGN0: begin
        tx_adv     = 1'b1;
        tx_bit_val = 1'b0;  // R8
      end
      OH_CBIT: begin
        tx_adv = 1'b1;
        // Path parity only in C-bit Parity; others from overhead input
        if (!format_m13 && state_reg.tx_sf == 3'h3) begin
          tx_bit_val = state_reg.tx_pbit;  // R10 R12
        end else begin
          tx_bit_val = tx_c_data;  // R11
        end
      end
      OH_PAYLOAD: begin
        tx_adv     = fifo_valid;  // R2
        tx_bit_val = fifo_data;
      end
      default: begin
        tx_adv     = 1'b0;
        tx_bit_val = 1'b0;
      end
    endcase

    state_next.tx_valid = tx_adv;
    state_next.tx_data  = tx_bit_val;
    state_next.tx_slot  = tx_adv && (tx_kind == OH_PAYLOAD);
    state_next.tx_start = tx_adv && (tx_kind == OH_LEAD) &&
                          (state_reg.tx_sf == FIRST_SUBFRAME);

    if (tx_adv) begin
      if (tx_kind == OH_PAYLOAD) begin
        state_next.tx_par = state_reg.tx_par ^ fifo_data;  // R14
      end
      if (state_reg.tx_bit == LAST_BIT_IN_BLOCK) begin  // R4
        state_next.tx_bit = 7'h00;
        if (state_reg.tx_blk == LAST_BLOCK) begin
          state_next.tx_blk = 3'h0;
          if (state_reg.tx_sf == LAST_SUBFRAME) begin  // R1 R3
            state_next.tx_sf   = FIRST_SUBFRAME;
            // Latched once so both P-bits agree; last bit is payload
            state_next.tx_pbit = state_reg.tx_par ^ fifo_data;  // R15 R14
            state_next.tx_par  = 1'b0;
          end else begin
            state_next.tx_sf = state_reg.tx_sf + 3'h1;
          end
        end else begin
          state_next.tx_blk = state_reg.tx_blk + 3'h1;
        end
      end else begin
        state_next.tx_bit = state_reg.tx_bit + 7'h01;
      end
    end

    // Receive map, aligned by the acquisition logic's start mark
    state_next.rx_valid  = 1'b0;
    state_next.rx_cvalid = 1'b0;
    if (rx_line_valid) begin
      state_next.rx_data   = rx_line_data;
      state_next.rx_valid  = (rx_kind == OH_PAYLOAD) || rx_mframe_start ?
                             !rx_mframe_start && (rx_kind == OH_PAYLOAD) :
                             1'b0;
      state_next.rx_cvalid = !rx_mframe_start && (rx_kind == OH_CBIT);
      if (rx_mframe_start) begin
        // Start bit is the lead of subframe 1; next bit is block 0 bit 1
        state_next.rx_bit  = 7'h01;
        state_next.rx_blk  = 3'h0;
        state_next.rx_sf   = FIRST_SUBFRAME;
        state_next.rx_ones = 2'h0;
      end else begin
        if (rx_kind == OH_CBIT) begin
          // Majority of three stuff-control bits
          rx_maj = (state_reg.rx_ones == 2'h2) ||
                   (state_reg.rx_ones == 2'h1 && rx_line_data);  // R9
          if (rx_cidx == 2'h2) begin
            state_next.rx_ones = 2'h0;
            state_next.rx_used = format_m13 && rx_maj;  // R9 R6
            state_next.rx_stuff[state_reg.rx_sf - 3'h1] =
              format_m13 && rx_maj;
          end else begin
            state_next.rx_ones = state_reg.rx_ones + 2'(rx_line_data);
          end
        end
        if (state_reg.rx_bit == LAST_BIT_IN_BLOCK) begin
          state_next.rx_bit = 7'h00;
          if (state_reg.rx_blk == LAST_BLOCK) begin
            state_next.rx_blk = 3'h0;
            state_next.rx_sf  = (state_reg.rx_sf == LAST_SUBFRAME) ?
                                FIRST_SUBFRAME : state_reg.rx_sf + 3'h1;
          end else begin
            state_next.rx_blk = state_reg.rx_blk + 3'h1;
          end
        end else begin
          state_next.rx_bit = state_reg.rx_bit + 7'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg       <= '0;
      state_reg.mode  <= MODE_CTRL_RESET;
      state_reg.tx_sf <= FIRST_SUBFRAME;
      state_reg.rx_sf <= FIRST_SUBFRAME;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata          = state_reg.rdata;
  assign tx_line_data       = state_reg.tx_data;
  assign tx_line_valid      = state_reg.tx_valid;
  assign tx_mframe_start    = state_reg.tx_start;
  assign tx_pay_slot        = state_reg.tx_slot;
  assign rx_pay_data        = state_reg.rx_data;
  assign rx_pay_valid       = state_reg.rx_valid;
  assign rx_cbit_valid      = state_reg.rx_cvalid;
  assign rx_stuff_used      = state_reg.rx_used;
  assign rx_cbit_parity_fmt = !state_reg.mode[FORMAT_BIT];

endmodule : ds3_mframe_overhead_map

// file: hdl/ds3_map_pkg.sv
package ds3_map_pkg;

  // ----------------------------------------------------------------
  // Frame geometry
  // ----------------------------------------------------------------
  localparam int unsigned MFRAME_BITS   = 4760;
  localparam int unsigned OH_BITS       = 56;
  localparam int unsigned PAYLOAD_BITS  = 4704;
  localparam int unsigned SUBFRAMES     = 7;
  localparam int unsigned SUBFRAME_BITS = 680;
  localparam int unsigned BLOCKS        = 8;
  localparam int unsigned BLOCK_BITS    = 85;
  localparam int unsigned GROUP_BITS    = 84;

  localparam logic [6:0] LAST_BIT_IN_BLOCK = 7'h54;
  localparam logic [2:0] LAST_BLOCK        = 3'h7;
  localparam logic [2:0] FIRST_SUBFRAME    = 3'h1;
  localparam logic [2:0] LAST_SUBFRAME     = 3'h7;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] OH_STATUS_OFFSET   = 8'h01;
  localparam logic [7:0] STUFF_STATUS_OFFSET = 8'h02;
  localparam logic [7:0] MODE_CTRL_RESET    = 8'h00;
  localparam int unsigned FORMAT_BIT        = 2;

  // ----------------------------------------------------------------
  // Buffering
  // ----------------------------------------------------------------
  localparam int unsigned FIFO_WIDTH = 1;
  localparam int unsigned FIFO_DEPTH = 8;

  // Formats
  typedef enum logic {
    FMT_CBIT_PARITY = 1'b0,
    FMT_M13         = 1'b1
  } ds3_format_t;

  // Role of an overhead slot within a subframe
  typedef enum logic [2:0] {
    OH_LEAD    = 3'b000,
    OH_ALIGN1  = 3'b001,
    OH_ALIGN0  = 3'b010,
    OH_CBIT    = 3'b011,
    OH_PAYLOAD = 3'b100
  } oh_kind_t;

endpackage : ds3_map_pkg

// file: hdl/ds3_bit_fifo.sv
`timescale 1ns/1ps

module ds3_bit_fifo #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // Full and empty from an explicit count avoid pointer aliasing
  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : ds3_bit_fifo

// file: hdl/ds3_oh_slot.sv
`timescale 1ns/1ps

module ds3_oh_slot
  import ds3_map_pkg::*;
(
  input  wire logic [6:0] bit_in_block,
  input  wire logic [2:0] block_idx,
  output oh_kind_t        kind,
  output logic [1:0]      cbit_idx
);

  // ----------------------------------------------------------------
  // Slot decode: lead, F1, C, F0, C, F0, C, F1
  // ----------------------------------------------------------------
  always_comb begin
    cbit_idx = 2'h0;
    if (bit_in_block != 7'h00) begin
      kind = OH_PAYLOAD;
    end else begin
      case (block_idx)
        3'h0: kind = OH_LEAD;  // R13
        3'h1: kind = OH_ALIGN1;
        3'h2: begin
          kind     = OH_CBIT;
          cbit_idx = 2'h0;
        end
        3'h3: kind = OH_ALIGN0;
        3'h4: begin
          kind     = OH_CBIT;
          cbit_idx = 2'h1;
        end
        3'h5: kind = OH_ALIGN0;
        3'h6: begin
          kind     = OH_CBIT;
          cbit_idx = 2'h2;
        end
        3'h7: kind = OH_ALIGN1;
        default: kind = OH_PAYLOAD;
      endcase
    end
  end

endmodule : ds3_oh_slot

// file: verif/ds3_map_asserts.sv
`timescale 1ns/1ps
module ds3_map_asserts
  import ds3_map_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       tx_c_data,
  input wire logic       tx_x_data,
  input wire logic       tx_line_data,
  input wire logic       tx_line_valid,
  input wire logic       tx_mframe_start,
  input wire logic       tx_pay_slot,
  input wire logic       rx_cbit_parity_fmt
);
  // ----------
  // Position of each emitted line bit
  // ----------
  logic [12:0] cnt_reg, pos;
  logic [7:0]  mode_reg;
  logic [2:0]  k, sf;
  logic        oh, lead, cs, par_reg, prev_reg, seen_reg;

  always_comb begin
    pos  = tx_mframe_start ? 13'h0 : cnt_reg;
    oh   = tx_line_valid && pos % BLOCK_BITS == 0;
    k    = 3'((pos / BLOCK_BITS) % BLOCKS);
    sf   = 3'(pos / SUBFRAME_BITS);
    lead = oh && k == 3'h0;
    cs   = oh && !k[0] && k != 3'h0;
  end

  // Stalls do not advance the count, only emitted bits do
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_reg  <= 13'h0;
      par_reg  <= 1'b0;
      prev_reg <= 1'b0;
      seen_reg <= 1'b0;
      mode_reg <= MODE_CTRL_RESET;
    end else begin
      if (tx_line_valid) begin
        cnt_reg  <= pos + 13'h1;
        seen_reg <= seen_reg | tx_mframe_start;
        if (tx_mframe_start) begin
          prev_reg <= par_reg;
          par_reg  <= 1'b0;
        end else if (tx_pay_slot) begin
          par_reg <= par_reg ^ tx_line_data;
        end
      end
      if (reg_wr && reg_addr == MODE_CTRL_OFFSET) begin
        mode_reg <= reg_wdata;
      end
    end
  end

  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence mode_wr; reg_wr && reg_addr == MODE_CTRL_OFFSET; endsequence
  sequence mode_rd; reg_rd && reg_addr == MODE_CTRL_OFFSET; endsequence

  chk_mframe_len: assert property (
    tx_line_valid && tx_mframe_start && seen_reg |->
    cnt_reg == 13'(MFRAME_BITS)) else $error("bad multiframe length");
  chk_slot_kind: assert property (
    tx_line_valid |-> tx_pay_slot == !oh) else $error("bad slot kind");
  chk_sub_align: assert property (
    oh && k[0] |-> tx_line_data == (k == 3'h1 || k == 3'h7))
    else $error("bad subframe align bit");
  chk_multi_align: assert property (
    lead && sf >= 3'h4 |-> tx_line_data == (sf == 3'h5))
    else $error("bad multiframe align bit");
  chk_x_bits: assert property (
    lead && sf < 3'h2 |-> tx_line_data == $past(tx_x_data))
    else $error("bad lead bit");
  chk_p_bits: assert property (
    lead && (sf == 3'h2 || sf == 3'h3) |-> tx_line_data == prev_reg)
    else $error("bad parity bit");
  chk_path_par: assert property (
    cs && sf == 3'h2 && $past(rx_cbit_parity_fmt) |->
    tx_line_data == prev_reg)
    else $error("bad path parity bit");
  chk_c_bits: assert property (
    cs && !(sf == 3'h2 && $past(rx_cbit_parity_fmt)) |->
    tx_line_data == $past(tx_c_data)) else $error("bad c bit");
  chk_fmt_flag: assert property (
    mode_wr |-> ##[1:2] rx_cbit_parity_fmt == !mode_reg[FORMAT_BIT])
    else $error("format flag wrong");
  chk_mode_read: assert property (
    mode_rd |=> reg_rdata == mode_reg) else $error("mode read wrong");
  chk_rd_idle: assert property (
    !reg_rd |=> reg_rdata == 8'h00) else $error("read data not idle");
endmodule : ds3_map_asserts

bind ds3_mframe_overhead_map ds3_map_asserts ds3_map_asserts_inst (
  .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .tx_c_data(tx_c_data), .tx_x_data(tx_x_data),
  .tx_line_data(tx_line_data), .tx_line_valid(tx_line_valid),
  .tx_mframe_start(tx_mframe_start), .tx_pay_slot(tx_pay_slot),
  .rx_cbit_parity_fmt(rx_cbit_parity_fmt)
);

// file: verif/ds3_far_end.sv
`timescale 1ns/1ps
module ds3_far_end
  import ds3_map_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic run,
  input  wire logic slow,
  input  wire logic c_val,
  output logic      line_data,
  output logic      line_valid,
  output logic      mframe_start
);
  logic [12:0] pos_reg;
  logic [2:0]  k, sf;
  logic        d, ph_reg;

  always_comb begin
    k  = 3'((pos_reg / BLOCK_BITS) % BLOCKS);
    sf = 3'(pos_reg / SUBFRAME_BITS);
    d  = pos_reg[0] ^ pos_reg[3];
    if (pos_reg % BLOCK_BITS == 0) begin
      case (k)
        3'h0:       d = sf < 3'h2 || sf == 3'h5;
        3'h1, 3'h7: d = 1'b1;
        3'h3, 3'h5: d = 1'b0;
        default:    d = c_val;
      endcase
    end
  end

  // Idle line toggles so a stale bit never reads as data
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pos_reg      <= 13'h0;
      ph_reg       <= 1'b0;
      line_valid   <= 1'b0;
      mframe_start <= 1'b0;
      line_data    <= 1'b0;
    end else if (!run || (slow && ph_reg)) begin
      ph_reg       <= 1'b0;
      line_valid   <= 1'b0;
      mframe_start <= 1'b0;
      line_data    <= ~line_data;
    end else begin
      ph_reg       <= 1'b1;
      line_valid   <= 1'b1;
      mframe_start <= pos_reg == 13'h0;
      line_data    <= d;
      pos_reg      <= pos_reg + 13'h1;
      if (pos_reg == 13'(MFRAME_BITS - 1)) begin
        pos_reg <= 13'h0;
      end
    end
  end
endmodule : ds3_far_end

// file: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import ds3_map_pkg::*;
;
  logic        ref_clk      = 1'b0;
  logic        rst          = 1'b1;
  logic        reg_wr       = 1'b0;
  logic        reg_rd       = 1'b0;
  logic [7:0]  reg_addr     = 8'h00;
  logic [7:0]  reg_wdata    = 8'h00;
  logic        tx_pay_data  = 1'b0;
  logic        tx_pay_valid = 1'b0;
  logic        tx_c_data    = 1'b0;
  logic        tx_x_data    = 1'b1;
  logic        run          = 1'b0;
  logic        slow         = 1'b0;
  logic        c_val        = 1'b0;
  logic        rx_prev      = 1'b0;
  logic [7:0]  pay_seq      = 8'h00;
  logic [12:0] oh_cnt       = 13'h0;
  logic [12:0] pay_cnt      = 13'h0;
  logic [15:0] rx_pay_n     = 16'h0;
  logic [15:0] rx_c_n       = 16'h0;
  logic [12:0] oh_last, pay_last;
  logic [7:0]  reg_rdata;
  logic        tx_pay_ready, tx_line_data, tx_line_valid, tx_mframe_start;
  logic        tx_pay_slot, rx_line_data, rx_line_valid, rx_mframe_start;
  logic        rx_pay_data, rx_pay_valid, rx_cbit_valid, rx_stuff_used;
  logic        rx_cbit_parity_fmt;
  logic        fed_q[$];
  int          fails        = 0;
  int          n_tests      = 0;
  int          cycles       = 0;

  ds3_mframe_overhead_map ds3_mframe_overhead_map_inst (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tx_pay_data(tx_pay_data),
    .tx_pay_valid(tx_pay_valid), .tx_pay_ready(tx_pay_ready),
    .tx_c_data(tx_c_data), .tx_x_data(tx_x_data),
    .tx_line_data(tx_line_data), .tx_line_valid(tx_line_valid),
    .tx_mframe_start(tx_mframe_start), .tx_pay_slot(tx_pay_slot),
    .rx_line_data(rx_line_data), .rx_line_valid(rx_line_valid),
    .rx_mframe_start(rx_mframe_start), .rx_pay_data(rx_pay_data),
    .rx_pay_valid(rx_pay_valid), .rx_cbit_valid(rx_cbit_valid),
    .rx_stuff_used(rx_stuff_used), .rx_cbit_parity_fmt(rx_cbit_parity_fmt)
  );
  ds3_far_end ds3_far_end_inst (
    .ref_clk(ref_clk), .rst(rst), .run(run), .slow(slow), .c_val(c_val),
    .line_data(rx_line_data), .line_valid(rx_line_valid),
    .mframe_start(rx_mframe_start)
  );

  initial forever #5 ref_clk = ~ref_clk;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [15:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask : check

  // ----------
  // Payload feed and line monitor
  // ----------
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    rx_prev <= rx_line_data;
    if (cycles == 90000) begin
      $display("Error timeout expected done seen hang");
      fails++;
      print_verdict();
    end
    if (!rst) begin
      rx_pay_n <= rx_pay_n + 16'(rx_pay_valid & ~rx_cbit_valid);
      rx_c_n   <= rx_c_n + 16'(rx_cbit_valid);
      if (tx_pay_valid && tx_pay_ready) begin
        fed_q.push_back(tx_pay_data);
        pay_seq     <= pay_seq + 8'h1;
        tx_pay_data <= pay_seq[1] ^ pay_seq[4];
      end
      if (tx_line_valid && tx_mframe_start) begin
        oh_last  <= oh_cnt;
        pay_last <= pay_cnt;
        oh_cnt   <= 13'h1;
        pay_cnt  <= 13'h0;
      end else if (tx_line_valid) begin
        oh_cnt  <= oh_cnt + 13'(!tx_pay_slot);
        pay_cnt <= pay_cnt + 13'(tx_pay_slot);
      end
      if (tx_line_valid && tx_pay_slot)
        check("line bit", 16'(fed_q.pop_front()), 16'(tx_line_data));
      if (rx_pay_valid || rx_cbit_valid)
        check("rx bit", 16'(rx_prev), 16'(rx_pay_data));
    end
  end

  // ----------
  // Bus and wait helpers
  // ----------
  task automatic reg_write(input logic [7:0] a, d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask : reg_read

  // Counts multiframe starts on the tx line or on the far-end line
  task automatic wait_start(input bit rx, input int n);
    int t;
    t = 0;
    while (n > 0 && t < 30000) begin
      @(negedge ref_clk);
      t++;
      if ((rx ? rx_line_valid && rx_mframe_start
              : tx_line_valid && tx_mframe_start) === 1'b1) n--;
    end
    check("start seen", 16'h0, 16'(n));
    @(negedge ref_clk);
  endtask : wait_start

  // ----------
  // Scenarios
  // ----------
  task automatic t_regs();
    logic [7:0] d;
    reg_read(MODE_CTRL_OFFSET, d);
    check("mode reset", 16'(MODE_CTRL_RESET), 16'(d));
    check("fmt reset", 16'h1, 16'(rx_cbit_parity_fmt));
    check("ready reset", 16'h1, 16'(tx_pay_ready));
    reg_write(8'h10, 8'hff);
    reg_read(8'h10, d);
    check("unmapped read", 16'h0, 16'(d));
    reg_write(MODE_CTRL_OFFSET, 8'hfb);
    reg_read(MODE_CTRL_OFFSET, d);
    check("mode rw", 16'hfb, 16'(d));
    check("fmt cbit", 16'h1, 16'(rx_cbit_parity_fmt));
    reg_write(MODE_CTRL_OFFSET, 8'h04);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    check("fmt m13", 16'h0, 16'(rx_cbit_parity_fmt));
    reg_write(MODE_CTRL_OFFSET, 8'h00);
    $display("test regs done");
  endtask : t_regs

  task automatic t_frames();
    @(posedge ref_clk);
    tx_pay_valid <= 1'b1;
    wait_start(1'b0, 3);
    check("oh bits", 16'(OH_BITS), 16'(oh_last));
    check("pay bits", 16'(PAYLOAD_BITS), 16'(pay_last));
    $display("test frames done");
  endtask : t_frames

  task automatic t_fifo();
    int t;
    t = 0;
    while (tx_pay_ready !== 1'b0 && t < 5000) begin
      @(negedge ref_clk);
      t++;
    end
    check("fifo full", 16'h0, 16'(tx_pay_ready));
    @(posedge ref_clk);
    tx_pay_valid <= 1'b0;
    repeat (20) @(negedge ref_clk);
    check("line stall", 16'h0, 16'(tx_line_valid));
    check("fifo empty", 16'h1, 16'(tx_pay_ready));
    @(posedge ref_clk);
    tx_pay_valid <= 1'b1;
    $display("test fifo done");
  endtask : t_fifo

  task automatic t_stuff();
    logic [7:0]  d;
    logic [15:0] p0, c0;
    reg_write(MODE_CTRL_OFFSET, 8'h04);
    @(posedge ref_clk);
    c_val     <= 1'b1;
    run       <= 1'b1;
    tx_c_data <= 1'b1;
    tx_x_data <= 1'b0;
    wait_start(1'b1, 2);
    p0 = rx_pay_n;
    c0 = rx_c_n;
    wait_start(1'b1, 1);
    check("rx pay bits", 16'(PAYLOAD_BITS), rx_pay_n - p0);
    check("rx c bits", 16'h15, rx_c_n - c0);
    reg_read(STUFF_STATUS_OFFSET, d);
    check("stuff all", 16'h7f, 16'(d));
    check("stuff flag", 16'h1, 16'(rx_stuff_used));
    @(posedge ref_clk);
    c_val <= 1'b0;
    slow  <= 1'b1;
    wait_start(1'b1, 2);
    reg_read(STUFF_STATUS_OFFSET, d);
    check("stuff none", 16'h0, 16'(d));
    reg_write(MODE_CTRL_OFFSET, 8'h00);
    @(posedge ref_clk);
    c_val <= 1'b1;
    slow  <= 1'b0;
    wait_start(1'b1, 2);
    check("stuff cbit", 16'h0, 16'(rx_stuff_used));
    reg_read(STUFF_STATUS_OFFSET, d);
    check("stuff cbit reg", 16'h0, 16'(d));
    $display("test stuff done");
  endtask : t_stuff

  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_frames();
    t_fifo();
    t_stuff();
    print_verdict();
  end
endmodule : tb_top
